// ==== src/ptm_pkg.sv ====
// Package of register map, field positions and encodings for the periodic timer
package ptm_pkg;
	localparam int PTM_CNT_W = 10;
	localparam logic [PTM_CNT_W-1:0] PTM_CNT_MAX = 10'h3ff;
	// Register byte addresses on the AXI4-Lite bus
	localparam logic [4:0] PTM_ADDR_CTRL0 = 5'h00;
	localparam logic [4:0] PTM_ADDR_CTRL1 = 5'h04;
	localparam logic [4:0] PTM_ADDR_CNT_LO = 5'h08;
	localparam logic [4:0] PTM_ADDR_CNT_HI = 5'h0c;
	localparam logic [4:0] PTM_ADDR_CMPA_LO = 5'h10;
	localparam logic [4:0] PTM_ADDR_CMPA_HI = 5'h14;
	localparam logic [4:0] PTM_ADDR_PER_LO = 5'h18;
	localparam logic [4:0] PTM_ADDR_PER_HI = 5'h1c;
	localparam int PTM_ADDR_W = 5;
	// Control 0 field positions
	localparam int PTM_C0_HOLD = 7;
	localparam int PTM_C0_CLK_HI = 6;
	localparam int PTM_C0_CLK_LO = 4;
	localparam int PTM_C0_RUN = 3;
	// Control 1 field positions
	localparam int PTM_C1_MODE_HI = 7;
	localparam int PTM_C1_MODE_LO = 6;
	localparam int PTM_C1_OFN_HI = 5;
	localparam int PTM_C1_OFN_LO = 4;
	localparam int PTM_C1_INIT = 3;
	localparam int PTM_C1_INV = 2;
	localparam int PTM_C1_CLR = 0;
	// Flag register: write one to clear
	localparam logic [4:0] PTM_ADDR_FLAGS = 5'h20;
	localparam int PTM_FL_A = 0;
	localparam int PTM_FL_P = 1;
	localparam logic [7:0] PTM_RST_BYTE = 8'h00;
	localparam logic [1:0] PTM_RESP_OKAY = 2'b00;
	localparam logic [1:0] PTM_RESP_SLVERR = 2'b10;
	// Modes and output functions
	localparam logic [1:0] PTM_MODE_CMP = 2'b00;
	localparam logic [1:0] PTM_MODE_PWM = 2'b10;
	localparam logic [1:0] PTM_MODE_TMR = 2'b11;
	localparam logic [1:0] PTM_OFN_NONE = 2'b00;
	localparam logic [1:0] PTM_OFN_LOW = 2'b01;
	localparam logic [1:0] PTM_OFN_HIGH = 2'b10;
	localparam logic [1:0] PTM_OFN_TOG = 2'b11;
	// Clock selects
	localparam logic [2:0] PTM_CK_DIV4 = 3'h0;
	localparam logic [2:0] PTM_CK_SYS = 3'h1;
	localparam logic [2:0] PTM_CK_DIV16 = 3'h2;
	localparam logic [2:0] PTM_CK_DIV64 = 3'h3;
	localparam logic [2:0] PTM_CK_SUB = 3'h4;
	localparam logic [2:0] PTM_CK_EXT_R = 3'h6;
	localparam logic [2:0] PTM_CK_EXT_F = 3'h7;
	localparam int PTM_SUB_DIV = 256;
endpackage : ptm_pkg

// ==== src/ptm_tick_gen.sv ====
// Timer clock enable generator: divided ticks and external pin edges
`timescale 1ns/1ps
module ptm_tick_gen
	import ptm_pkg::*;
#(
	parameter int SUB_DIV = PTM_SUB_DIV
)(
	input  wire logic       i_clock,     // System clock
	input  wire logic       i_sys_rst,   // Async reset, active high
	input  wire logic [2:0] i_clk_sel,   // Timer clock select
	input  wire logic       i_ext_pin,   // External clock pin, asynchronous
	output logic            o_tick,      // One-cycle timer clock enable
	output logic            o_ext_rise,  // One-cycle rising edge of pin
	output logic            o_ext_fall   // One-cycle falling edge of pin
);
	// Div4/16/64 ticks use the low divider bits, so the wrap must be a multiple of 64
	if (SUB_DIV < 64 || SUB_DIV > 65536 || SUB_DIV % 64 != 0)
	begin : g_bad_sub_div
		$error("SUB_DIV out of range");
	end

	logic [15:0] div_reg;
	logic        sync1_reg;
	logic        sync2_reg;
	logic        sync3_reg;
	logic        tick_next;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			div_reg <= 16'h0000;
		else if (div_reg == 16'(SUB_DIV - 1))
			div_reg <= 16'h0000;
		else
			div_reg <= div_reg + 16'h0001;
	end

	// Pin synchroniser plus one stage for edge detection
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= i_ext_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	always_comb
	begin
		case (i_clk_sel)
			PTM_CK_DIV4:  tick_next = (div_reg[1:0] == 2'h3);
			PTM_CK_SYS:   tick_next = 1'b1;
			PTM_CK_DIV16: tick_next = (div_reg[3:0] == 4'hf);
			PTM_CK_DIV64: tick_next = (div_reg[5:0] == 6'h3f);
			PTM_CK_SUB:   tick_next = (div_reg == 16'(SUB_DIV - 1));
			PTM_CK_EXT_R: tick_next = sync2_reg & ~sync3_reg;
			PTM_CK_EXT_F: tick_next = ~sync2_reg & sync3_reg;
			default:      tick_next = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_tick     <= 1'b0;
			o_ext_rise <= 1'b0;
			o_ext_fall <= 1'b0;
		end
		else
		begin
			o_tick     <= tick_next;
			o_ext_rise <= sync2_reg & ~sync3_reg;
			o_ext_fall <= ~sync2_reg & sync3_reg;
		end
	end
endmodule : ptm_tick_gen

// ==== src/ptm_timer.sv ====
// 10-bit periodic timer with AXI4-Lite registers
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ptm_timer
	import ptm_pkg::*;
#(
	parameter int SUB_DIV = PTM_SUB_DIV
)(
	input  wire logic        i_clock,          // System clock 100 MHz
	input  wire logic        i_sys_rst,        // Async reset, active high
	input  wire logic [4:0]  i_s_axi_awaddr,   // Write address
	input  wire logic        i_s_axi_awvalid,  // Write address valid
	output logic             o_s_axi_awready,  // Write address ready
	input  wire logic [31:0] i_s_axi_wdata,    // Write data
	input  wire logic [3:0]  i_s_axi_wstrb,    // Write strobes
	input  wire logic        i_s_axi_wvalid,   // Write data valid
	output logic             o_s_axi_wready,   // Write data ready
	output logic [1:0]       o_s_axi_bresp,    // Write response
	output logic             o_s_axi_bvalid,   // Write response valid
	input  wire logic        i_s_axi_bready,   // Write response ready
	input  wire logic [4:0]  i_s_axi_araddr,   // Read address
	input  wire logic        i_s_axi_arvalid,  // Read address valid
	output logic             o_s_axi_arready,  // Read address ready
	output logic [31:0]      o_s_axi_rdata,    // Read data
	output logic [1:0]       o_s_axi_rresp,    // Read response
	output logic             o_s_axi_rvalid,   // Read data valid
	input  wire logic        i_s_axi_rready,   // Read data ready
	input  wire logic        i_ext_clock_pin,  // External clock / trigger pin
	output logic             o_timer_out_pin0, // Timer output pin 0
	output logic             o_timer_out_pin1, // Timer output pin 1
	output logic             o_timer_out_en,   // High when the timer drives the pins
	output logic             o_match_a_flag,   // Comparator A flag
	output logic             o_match_p_flag    // Comparator P flag
);
	logic [7:0]           ctrl0_reg;
	logic [7:0]           ctrl1_reg;
	logic [PTM_CNT_W-1:0] cmpa_reg;
	logic [PTM_CNT_W-1:0] per_reg;
	logic [PTM_CNT_W-1:0] cnt_reg;
	logic                 run_d_reg;
	logic                 pin_reg;
	logic                 flag_a_reg;
	logic                 flag_p_reg;
	logic                 tick;
	logic                 ext_rise;
	logic                 ext_fall;

	logic [4:0]  awaddr_reg;
	logic        aw_have_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        w_have_reg;

	wire  logic [1:0] mode_select  = ctrl1_reg[PTM_C1_MODE_HI:PTM_C1_MODE_LO];
	wire  logic [1:0] out_function = ctrl1_reg[PTM_C1_OFN_HI:PTM_C1_OFN_LO];
	wire  logic       out_init_level      = ctrl1_reg[PTM_C1_INIT];
	wire  logic       out_invert          = ctrl1_reg[PTM_C1_INV];
	wire  logic       clear_source_select = ctrl1_reg[PTM_C1_CLR];
	wire  logic       counter_run  = ctrl0_reg[PTM_C0_RUN];
	wire  logic       counter_hold = ctrl0_reg[PTM_C0_HOLD];
	wire  logic [2:0] clk_sel      = ctrl0_reg[PTM_C0_CLK_HI:PTM_C0_CLK_LO];

	ptm_tick_gen #(
		.SUB_DIV(SUB_DIV)
	) u_tick (
		.i_clock    (i_clock),
		.i_sys_rst  (i_sys_rst),
		.i_clk_sel  (clk_sel),
		.i_ext_pin  (i_ext_clock_pin),
		.o_tick     (tick),
		.o_ext_rise (ext_rise),
		.o_ext_fall (ext_fall)
	);

	// Mode decode
	logic is_cmp_like;
	logic is_pwm;
	logic is_single;
	logic run_rise;
	logic advance;
	logic [PTM_CNT_W-1:0] cnt_inc;
	logic match_a;
	logic match_p;
	logic ovf;
	logic clear_cnt;
	logic set_a;
	logic set_p;
	logic trigger;
	logic single_end;

	always_comb
	begin
		is_cmp_like = (mode_select == PTM_MODE_CMP) || (mode_select == PTM_MODE_TMR);
		is_pwm      = (mode_select == PTM_MODE_PWM) && (out_function != PTM_OFN_TOG);
		is_single   = (mode_select == PTM_MODE_PWM) && (out_function == PTM_OFN_TOG);
		run_rise    = counter_run & ~run_d_reg;
		advance     = counter_run & ~counter_hold & tick & ~run_rise;
		cnt_inc     = cnt_reg + 10'h001;
		ovf         = advance && (cnt_reg == PTM_CNT_MAX);
		// Matches fire as the count steps onto the compare value
		match_a     = advance && (cmpa_reg != 10'h000) && (cnt_inc == cmpa_reg);
		match_p     = advance && (per_reg != 10'h000) && (cnt_inc == per_reg);
		clear_cnt   = 1'b0;
		set_a       = 1'b0;
		set_p       = 1'b0;
		single_end  = 1'b0;
		if (is_cmp_like)
		begin
			set_a = match_a;
			if (clear_source_select)
			begin
				clear_cnt = match_a || ovf;
			end
			else
			begin
				clear_cnt = match_p || (per_reg == 10'h000 && ovf);
				set_p     = match_p || (per_reg == 10'h000 && ovf);
			end
		end
		else if (is_pwm)
		begin
			clear_cnt = match_p || ovf;
			set_a     = match_a;
			set_p     = match_p || (per_reg == 10'h000 && ovf);
		end
		else if (is_single)
		begin
			set_a      = match_a;
			single_end = match_a;
		end
	end

	// Pin edge starts a single pulse when the run bit is low
	always_comb
	begin
		trigger = is_single && !counter_run &&
			((clk_sel == PTM_CK_EXT_F) ? ext_fall : ext_rise);
	end

	// Counter
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cnt_reg <= 10'h000;
		else if (run_rise)
			cnt_reg <= 10'h000;
		else if (advance)
		begin
			if (clear_cnt)
				cnt_reg <= 10'h000;
			else
				cnt_reg <= cnt_inc;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			run_d_reg <= 1'b0;
		else
			run_d_reg <= counter_run;
	end

	// Output level
	logic pwm_active;
	always_comb
	begin
		if (per_reg == 10'h000)
			pwm_active = (cnt_reg < cmpa_reg);
		else
			pwm_active = (cnt_reg < cmpa_reg) || (cmpa_reg >= per_reg);
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			pin_reg <= 1'b0;
		else if (mode_select == PTM_MODE_CMP)
		begin
			if (run_rise)
				pin_reg <= out_init_level;
			else if (set_a)
			begin
				case (out_function)
					PTM_OFN_LOW:  pin_reg <= 1'b0;
					PTM_OFN_HIGH: pin_reg <= 1'b1;
					PTM_OFN_TOG:  pin_reg <= ~pin_reg;
					default:      pin_reg <= pin_reg;
				endcase
			end
		end
		else if (is_single)
		begin
			if (run_rise)
				pin_reg <= out_init_level;
			else if (single_end || !counter_run)
				pin_reg <= ~out_init_level;
		end
		else if (is_pwm)
		begin
			case (out_function)
				PTM_OFN_NONE: pin_reg <= ~out_init_level;
				PTM_OFN_LOW:  pin_reg <= out_init_level;
				default:      pin_reg <= pwm_active ? out_init_level : ~out_init_level;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_timer_out_pin0 <= 1'b0;
			o_timer_out_pin1 <= 1'b0;
			o_timer_out_en   <= 1'b0;
		end
		else
		begin
			o_timer_out_pin0 <= pin_reg ^ out_invert;
			o_timer_out_pin1 <= pin_reg ^ out_invert;
			o_timer_out_en   <= (mode_select != PTM_MODE_TMR);
		end
	end

	// Register bus
	logic wr_go;
	logic rd_go;
	logic [4:0] rd_addr;
	always_comb
	begin
		wr_go   = aw_have_reg && w_have_reg && !o_s_axi_bvalid;
		rd_go   = i_s_axi_arvalid && o_s_axi_arready;
		rd_addr = i_s_axi_araddr;
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			aw_have_reg     <= 1'b0;
			w_have_reg      <= 1'b0;
			awaddr_reg      <= 5'h00;
			wdata_reg       <= 32'h0000_0000;
			wstrb_reg       <= 4'h0;
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready  <= 1'b1;
			o_s_axi_bvalid  <= 1'b0;
			o_s_axi_bresp   <= PTM_RESP_OKAY;
		end
		else
		begin
			if (i_s_axi_awvalid && o_s_axi_awready)
			begin
				awaddr_reg      <= i_s_axi_awaddr;
				aw_have_reg     <= 1'b1;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready)
			begin
				wdata_reg      <= i_s_axi_wdata;
				wstrb_reg      <= i_s_axi_wstrb;
				w_have_reg     <= 1'b1;
				o_s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				aw_have_reg    <= 1'b0;
				w_have_reg     <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp  <= (awaddr_reg[1:0] == 2'b00 && awaddr_reg <= PTM_ADDR_PER_HI)
					|| awaddr_reg == PTM_ADDR_FLAGS ? PTM_RESP_OKAY : PTM_RESP_SLVERR;
			end
			if (o_s_axi_bvalid && i_s_axi_bready)
			begin
				o_s_axi_bvalid  <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready  <= 1'b1;
			end
		end
	end

	logic wr_lane0;
	always_comb
	begin
		wr_lane0 = wr_go && wstrb_reg[0];
	end

	// Control and value registers
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ctrl0_reg <= PTM_RST_BYTE;
			ctrl1_reg <= PTM_RST_BYTE;
			cmpa_reg  <= 10'h000;
			per_reg   <= 10'h000;
		end
		else
		begin
			if (wr_lane0 && awaddr_reg == PTM_ADDR_CTRL0)
				ctrl0_reg <= {wdata_reg[7:3], 3'b000};
			else if (trigger)
				ctrl0_reg[PTM_C0_RUN] <= 1'b1;
			else if (single_end)
				ctrl0_reg[PTM_C0_RUN] <= 1'b0;
			if (wr_lane0 && awaddr_reg == PTM_ADDR_CTRL1)
				ctrl1_reg <= wdata_reg[7:0];
			if (wr_lane0 && awaddr_reg == PTM_ADDR_CMPA_LO)
				cmpa_reg[7:0] <= wdata_reg[7:0];
			if (wr_lane0 && awaddr_reg == PTM_ADDR_CMPA_HI)
				cmpa_reg[9:8] <= wdata_reg[1:0];
			if (wr_lane0 && awaddr_reg == PTM_ADDR_PER_LO)
				per_reg[7:0] <= wdata_reg[7:0];
			if (wr_lane0 && awaddr_reg == PTM_ADDR_PER_HI)
				per_reg[9:8] <= wdata_reg[1:0];
		end
	end

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			flag_a_reg <= 1'b0;
			flag_p_reg <= 1'b0;
		end
		else
		begin
			if (set_a)
				flag_a_reg <= 1'b1;
			else if (wr_lane0 && awaddr_reg == PTM_ADDR_FLAGS && wdata_reg[PTM_FL_A])
				flag_a_reg <= 1'b0;
			if (set_p)
				flag_p_reg <= 1'b1;
			else if (wr_lane0 && awaddr_reg == PTM_ADDR_FLAGS && wdata_reg[PTM_FL_P])
				flag_p_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_match_a_flag <= 1'b0;
			o_match_p_flag <= 1'b0;
		end
		else
		begin
			o_match_a_flag <= flag_a_reg | set_a;
			o_match_p_flag <= flag_p_reg | set_p;
		end
	end

	// Read channel
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_rdata   <= 32'h0000_0000;
			o_s_axi_rresp   <= PTM_RESP_OKAY;
		end
		else if (rd_go)
		begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid  <= 1'b1;
			o_s_axi_rresp   <= PTM_RESP_OKAY;
			case (rd_addr)
				PTM_ADDR_CTRL0:   o_s_axi_rdata <= {24'h000000, ctrl0_reg};
				PTM_ADDR_CTRL1:   o_s_axi_rdata <= {24'h000000, ctrl1_reg};
				PTM_ADDR_CNT_LO:  o_s_axi_rdata <= {24'h000000, cnt_reg[7:0]};
				PTM_ADDR_CNT_HI:  o_s_axi_rdata <= {30'h0, cnt_reg[9:8]};
				PTM_ADDR_CMPA_LO: o_s_axi_rdata <= {24'h000000, cmpa_reg[7:0]};
				PTM_ADDR_CMPA_HI: o_s_axi_rdata <= {30'h0, cmpa_reg[9:8]};
				PTM_ADDR_PER_LO:  o_s_axi_rdata <= {24'h000000, per_reg[7:0]};
				PTM_ADDR_PER_HI:  o_s_axi_rdata <= {30'h0, per_reg[9:8]};
				PTM_ADDR_FLAGS:   o_s_axi_rdata <= {30'h0, flag_p_reg, flag_a_reg};
				default:
				begin
					o_s_axi_rdata <= 32'h0000_0000;
					o_s_axi_rresp <= PTM_RESP_SLVERR;
				end
			endcase
		end
		else if (o_s_axi_rvalid && i_s_axi_rready)
		begin
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end
endmodule : ptm_timer

// ==== tb/ptm_timer_monitor.sv ====
// Checker of bus handshakes, flags and output pins of the periodic timer
`timescale 1ns/1ps
module ptm_timer_monitor
(
	input wire logic        i_clock,          // Clock
	input wire logic        i_sys_rst,        // Reset
	input wire logic        i_s_axi_awvalid,  // AW valid
	input wire logic        o_s_axi_awready,  // AW ready
	input wire logic        i_s_axi_wvalid,   // W valid
	input wire logic        o_s_axi_wready,   // W ready
	input wire logic        o_s_axi_bvalid,   // B valid
	input wire logic        i_s_axi_bready,   // B ready
	input wire logic        i_s_axi_arvalid,  // AR valid
	input wire logic        o_s_axi_arready,  // AR ready
	input wire logic [31:0] o_s_axi_rdata,    // R data
	input wire logic        o_s_axi_rvalid,   // R valid
	input wire logic        i_s_axi_rready,   // R ready
	input wire logic        o_timer_out_pin0, // Pin 0
	input wire logic        o_timer_out_pin1, // Pin 1
	input wire logic        o_match_a_flag,   // Flag A
	input wire logic        o_match_p_flag    // Flag P
);
	default clocking mon_cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);

	bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
		else $error("write response withdrawn early");
	rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data withdrawn or changed early");
	wr_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write accepted while response pending");
	rd_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read accepted while data pending");
	wr_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
		&& o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
		|=> o_s_axi_rvalid && !o_s_axi_arready)
		else $error("read data late");
	// A flag clear lands on the edge that raises bvalid and shows one edge later
	flag_a_keep_a: assert property (o_match_a_flag && !o_s_axi_bvalid |=> o_match_a_flag)
		else $error("flag A lost without clear");
	flag_p_keep_a: assert property (o_match_p_flag && !o_s_axi_bvalid |=> o_match_p_flag)
		else $error("flag P lost without clear");
	pins_agree_a: assert property (o_timer_out_pin0 == o_timer_out_pin1)
		else $error("output pins differ");
endmodule : ptm_timer_monitor

bind ptm_timer ptm_timer_monitor u_ptm_timer_monitor (
	.i_clock, .i_sys_rst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
	.o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
	.o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .o_timer_out_pin0, .o_timer_out_pin1,
	.o_match_a_flag, .o_match_p_flag
);

// ==== tb/ptm_timer_tb.sv ====
// Self-checking bench of the periodic timer
`timescale 1ns/1ps
module ptm_timer_tb
	import ptm_pkg::*;
;
	logic        i_clock, i_sys_rst, i_ext_clock_pin, ini, inv;
	logic [4:0]  i_s_axi_awaddr, i_s_axi_araddr;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
	logic [3:0]  i_s_axi_wstrb;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, resp;
	logic        i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
	logic        i_s_axi_rready, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
	logic        o_s_axi_arready, o_s_axi_rvalid, o_timer_out_pin0, o_timer_out_pin1;
	logic        o_timer_out_en, o_match_a_flag, o_match_p_flag;
	logic [7:0]  rd, v;
	logic [9:0]  c1, c2;
	int          err_total, total_checks, hi, p, a;
	logic [4:0]  rg [4] = '{PTM_ADDR_CMPA_LO, PTM_ADDR_CMPA_HI, PTM_ADDR_PER_LO, PTM_ADDR_PER_HI};

	ptm_timer #(.SUB_DIV(64)) u_ptm_timer (
		.i_clock, .i_sys_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
		.o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
		.o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_ext_clock_pin,
		.o_timer_out_pin0, .o_timer_out_pin1, .o_timer_out_en, .o_match_a_flag, .o_match_p_flag
	);

	always #5 i_clock = ~i_clock;

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wd(inout int n);
		n++;
		if (n > 300)
		begin
			chk("bus wait", 0, 1);
			test_done();
		end
	endtask : wd

	task automatic wr(input logic [4:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		i_s_axi_awaddr <= ad;
		i_s_axi_wdata <= {24'h000000, d};
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		forever
		begin
			@(posedge i_clock);
			wd(n);
			if (o_s_axi_awready)
				i_s_axi_awvalid <= 1'b0;
			if (o_s_axi_wready)
				i_s_axi_wvalid <= 1'b0;
			if (o_s_axi_bvalid && i_s_axi_bready)
				break;
			if ($urandom_range(1))
				i_s_axi_bready <= 1'b1;
		end
		resp = o_s_axi_bresp;
		i_s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [4:0] ad);
		int n;
		n = 0;
		@(posedge i_clock);
		i_s_axi_araddr <= ad;
		i_s_axi_arvalid <= 1'b1;
		forever
		begin
			@(posedge i_clock);
			wd(n);
			if (o_s_axi_arready)
				i_s_axi_arvalid <= 1'b0;
			if (o_s_axi_rvalid && i_s_axi_rready)
				break;
			if ($urandom_range(1))
				i_s_axi_rready <= 1'b1;
		end
		rd = o_s_axi_rdata[7:0];
		resp = o_s_axi_rresp;
		i_s_axi_rready <= 1'b0;
	endtask : rdr

	task automatic rdc(output logic [9:0] c);
		rdr(PTM_ADDR_CNT_LO);
		c[7:0] = rd;
		rdr(PTM_ADDR_CNT_HI);
		c[9:8] = rd[1:0];
	endtask : rdc

	task automatic rst;
		@(posedge i_clock);
		i_sys_rst <= 1'b1;
		repeat (4) @(posedge i_clock);
		i_sys_rst <= 1'b0;
	endtask : rst

	// Reset clears the flags, then mode, compare, period and control 0 are loaded
	task automatic cfg(input logic [7:0] m, input logic [9:0] ca, input logic [9:0] cp,
		input logic [7:0] c0);
		rst();
		wr(PTM_ADDR_CTRL1, m);
		wr(PTM_ADDR_CMPA_LO, ca[7:0]);
		wr(PTM_ADDR_CMPA_HI, {6'h00, ca[9:8]});
		wr(PTM_ADDR_PER_LO, cp[7:0]);
		wr(PTM_ADDR_PER_HI, {6'h00, cp[9:8]});
		wr(PTM_ADDR_CTRL0, c0);
	endtask : cfg

	// Pin-high cycles over k periods
	function automatic int pwm_hi(int pp, int aa, int f, logic act, int k);
		int on;
		on = (f == 2) ? ((aa >= pp) ? pp : aa) : ((f == 1) ? pp : 0);
		return act ? on * k : (pp - on) * k;
	endfunction : pwm_hi

	initial
	begin
		i_clock = 1'b0;
		i_sys_rst = 1'b1;
		i_ext_clock_pin = 1'b0;
		i_s_axi_awaddr = 5'h00;
		i_s_axi_araddr = 5'h00;
		i_s_axi_wdata = 32'h00000000;
		i_s_axi_wstrb = 4'h1;
		i_s_axi_awvalid = 1'b0;
		i_s_axi_wvalid = 1'b0;
		i_s_axi_bready = 1'b0;
		i_s_axi_arvalid = 1'b0;
		i_s_axi_rready = 1'b0;
		err_total = 0;
		total_checks = 0;
		void'($urandom(32'had517007));
		rst();
		foreach (rg[i])
		begin
			rdr(rg[i]);
			chk("reset value", 8'h00, rd);
		end
		repeat (4)
			foreach (rg[i])
			begin
				v = 8'($urandom);
				wr(rg[i], v);
				rdr(rg[i]);
				chk("readback", i[0] ? v & 8'h03 : v, rd);
			end
		wr(5'h1e, 8'h00);
		chk("bresp unmapped", PTM_RESP_SLVERR, resp);
		rdr(5'h1e);
		chk("rresp unmapped", PTM_RESP_SLVERR, resp);
		rdr(PTM_ADDR_PER_HI);
		chk("rresp mapped", PTM_RESP_OKAY, resp);
		$display("register test done");
		for (int f = 0; f < 4; f++)
		begin
			ini = 1'($urandom);
			cfg({2'b00, 2'(f), ini, 3'b000}, 10'd40, 10'd0, 8'h18);
			repeat (2) @(posedge i_clock);
			chk("pin initial", ini, o_timer_out_pin0);
			chk("pins driven", 1, o_timer_out_en);
			repeat (60) @(posedge i_clock);
			chk("pin on match", (f == 0) ? ini : (f == 3) ? !ini : f[1], o_timer_out_pin0);
			chk("flag a", 1, o_match_a_flag);
			chk("flag p early", 0, o_match_p_flag);
			repeat (1000) @(posedge i_clock);
			chk("flag p overflow", 1, o_match_p_flag);
		end
		cfg(8'h01, 10'd40, 10'd10, 8'h18);
		repeat (200) @(posedge i_clock);
		chk("flag a clear a", 1, o_match_a_flag);
		chk("flag p clear a", 0, o_match_p_flag);
		wr(PTM_ADDR_CTRL0, 8'h10);
		rdc(c1);
		chk("count below a", 1, c1 < 10'd40);
		wr(PTM_ADDR_FLAGS, 8'h01);
		repeat (2) @(posedge i_clock);
		chk("flag a cleared", 0, o_match_a_flag);
		cfg(8'h00, 10'd0, 10'd0, 8'h18);
		repeat (1100) @(posedge i_clock);
		chk("flag a zero", 0, o_match_a_flag);
		chk("flag p zero", 1, o_match_p_flag);
		cfg(8'he8, 10'd40, 10'd50, 8'h18);
		repeat (200) @(posedge i_clock);
		chk("pins free", 0, o_timer_out_en);
		chk("flags timer", 2'b11, {o_match_a_flag, o_match_p_flag});
		$display("compare test done");
		cfg(8'hc0, 10'd0, 10'd0, 8'h18);
		repeat (100) @(posedge i_clock);
		wr(PTM_ADDR_CTRL0, 8'h98);
		rdc(c1);
		repeat (20) @(posedge i_clock);
		rdc(c2);
		chk("held count", c1, c2);
		wr(PTM_ADDR_CTRL0, 8'h18);
		wr(PTM_ADDR_CTRL0, 8'h10);
		rdc(c2);
		chk("resumed count", 1, c2 > c1 && c2 < c1 + 10'd30);
		wr(PTM_ADDR_CNT_LO, 8'h55);
		repeat (20) @(posedge i_clock);
		rdc(c1);
		chk("stopped count", c2, c1);
		wr(PTM_ADDR_CTRL0, 8'h18);
		wr(PTM_ADDR_CTRL0, 8'h10);
		rdc(c1);
		chk("restart count", 1, c1 < 10'd30);
		$display("count test done");
		for (int i = 0; i < 6; i++)
		begin
			p = 8 + $urandom_range(31);
			a = (i > 2) ? p + $urandom_range(2) : 1 + $urandom_range(p - 2);
			ini = 1'($urandom);
			inv = 1'($urandom);
			cfg({2'b10, 2'(i % 3), ini, inv, 1'b0, 1'($urandom)}, 10'(a), 10'(p), 8'h18);
			repeat (2 * p + 10) @(posedge i_clock);
			hi = 0;
			repeat (4 * p)
			begin
				@(posedge i_clock);
				hi += o_timer_out_pin0;
			end
			chk("pwm high time", pwm_hi(p, a, i % 3, ini ^ inv, 4), hi);
			chk("pwm flag p", 1, o_match_p_flag);
			if (i < 3)
				chk("pwm flag a", 1, o_match_a_flag);
		end
		$display("pwm test done");
		cfg(8'hb8, 10'd20, 10'd5, 8'h10);
		repeat (5) @(posedge i_clock);
		chk("pulse idle", 0, o_timer_out_pin0);
		i_ext_clock_pin <= 1'b1;
		hi = 0;
		repeat (60)
		begin
			@(posedge i_clock);
			hi += o_timer_out_pin0;
		end
		chk("pulse width", 20, hi);
		rdr(PTM_ADDR_CTRL0);
		chk("run cleared", 0, rd[3]);
		chk("pulse flags", 2'b10, {o_match_a_flag, o_match_p_flag});
		i_ext_clock_pin <= 1'b0;
		wr(PTM_ADDR_CTRL0, 8'h18);
		repeat (3) @(posedge i_clock);
		chk("pulse lead", 1, o_timer_out_pin0);
		wr(PTM_ADDR_CTRL0, 8'h10);
		repeat (2) @(posedge i_clock);
		chk("pulse abort", 0, o_timer_out_pin0);
		$display("pulse test done");
		test_done();
	end
endmodule : ptm_timer_tb
